// *** rtl/ivp_consts.svh ***
`ifndef IVP_CONSTS_SVH
`define IVP_CONSTS_SVH
// Register indices; byte address is four times the index
`define IVP_IDX_TCTRL 8'h88
`define IVP_IDX_FLAGS_A 8'h91
`define IVP_IDX_BASE_EN 8'hA8
`define IVP_IDX_BASE_PRIO 8'hB8
`define IVP_IDX_STATUS 8'hC0
`define IVP_IDX_FLAGS_B 8'hD8
`define IVP_IDX_EXT_EN_A 8'hE8
`define IVP_IDX_EXT_EN_B 8'hE9
`define IVP_IDX_EXT_PRIO_A 8'hF8
`define IVP_IDX_EXT_PRIO_B 8'hF9
// Field positions
`define IVP_BIT_EXT0 1
`define IVP_BIT_EXT1 3
`define IVP_BIT_TMR0 5
`define IVP_BIT_TMR1 7
`define IVP_BIT_TMR3 7
`define IVP_BIT_CIPHER 6
`define IVP_BIT_TMR2 5
`define IVP_BIT_SLEEP 1
`define IVP_BIT_WAKE 0
`define IVP_BIT_GLOBAL 7
// Writable masks, reset values
`define IVP_MASK_FLAGS_A 8'hE0
`define IVP_MASK_FLAGS_B 8'h03
`define IVP_MASK_BASE 8'hDF
`define IVP_MASK_EXT_B 8'h0F
`define IVP_RST_REG 8'h00
// Vector address = base + step * source
`define IVP_VEC_BASE 16'h0003
`define IVP_VEC_SHIFT 3
`define IVP_NUM_SRC 18
`define IVP_GPIO_EXCL 32'h0C00_0000
`endif

// *** rtl/ivp_pkg.sv ***
package ivp_pkg;
  typedef enum logic [1:0] {BUS_IDLE, BUS_WR, BUS_RD_WAIT, BUS_RD_DONE} ivp_bus_st_t;
  typedef logic [4:0] ivp_src_id_t;
endpackage

// *** rtl/ivp_lowest_pick.sv ***
`timescale 1ns/1ps
// Picks the lowest-numbered set request
module ivp_lowest_pick
  import ivp_pkg::*;
#(
  parameter int N = 18
)
(
  input wire logic [N-1:0] req, // Candidate requests
  output logic valid, // Any request set
  output ivp_src_id_t idx // Lowest set index
);
  always_comb
  begin
    valid = |req;
    idx = '0;
    // Walk downward so the lowest index is written last
    for (int i = N - 1; i >= 0; i--)
    begin
      if (req[i])
      begin
        idx = ivp_src_id_t'(i);
      end
    end
  end
endmodule

// *** rtl/ivp_ctrl.sv ***
// Added by the designer: the AHB-Lite register port.
`timescale 1ns/1ps
`include "ivp_consts.svh"
module ivp_ctrl
  import ivp_pkg::*;
#(
  parameter int NUM_SRC = `IVP_NUM_SRC,
  parameter int DMA_SUBS = 24,
  parameter int GPIO_W = 32,
  parameter logic [31:0] GPIO_EXCL = `IVP_GPIO_EXCL
)
(
  input wire logic hclk, // System clock
  input wire logic hresetn, // Async reset, low
  input wire logic hsel, // Slave select
  input wire logic [31:0] haddr, // Byte address
  input wire logic [1:0] htrans, // Transfer type
  input wire logic hwrite, // Write strobe
  input wire logic [2:0] hsize, // Word only
  input wire logic [31:0] hwdata, // Write data
  input wire logic hready, // Bus ready
  output logic [31:0] hrdata, // Read data
  output logic hreadyout, // Slave ready
  output logic hresp, // Always OKAY
  input wire logic ext_pin_zero_n, // External pin 0, low active
  input wire logic ext_pin_one_n, // External pin 1, low active
  input wire logic timer0_ovf, // Timer0 overflow pulse
  input wire logic timer1_ovf, // Timer1 overflow pulse
  input wire logic timer2_evt, // Timer2 event pulse
  input wire logic timer3_evt, // Timer3 event pulse
  input wire logic cipher_done_evt, // Cipher done pulse
  input wire logic sleep_timeout_evt, // Sleep timer pulse
  input wire logic wakeup_evt, // Power-down wakeup pulse
  input wire logic [3:0] uart0_cause, // Serial 0 cause reg
  input wire logic [3:0] uart1_cause, // Serial 1 cause reg
  input wire logic ir_tx_irq, // IR modulator level
  input wire logic i2c_irq, // I2C level
  input wire logic radio_irq, // Radio layer level
  input wire logic serial_done_flag, // SPI completion
  input wire logic serial_local_enable, // SPI local enable
  input wire logic [DMA_SUBS-1:0] dma_flags, // DMA sub flags
  input wire logic [DMA_SUBS-1:0] dma_enables, // DMA sub enables
  input wire logic [GPIO_W-1:0] gpio_pin_flags, // GPIO pin flags
  input wire logic pwm_irq, // PWM level
  output logic irq_req, // Request to core
  output logic [15:0] irq_vector, // Vector address
  input wire logic irq_ack, // Core grant pulse
  input wire logic irq_ret // Routine return pulse
);
  ivp_bus_st_t bus_q;
  logic [7:0] idx_q;
  logic hit_q;
  logic [31:0] hrdata_q;
  logic [7:0] tctrl_q, flags_a_q, flags_b_q;
  logic [7:0] base_en_q, ext_en_a_q, ext_en_b_q;
  logic [7:0] base_pr_q, ext_pr_a_q, ext_pr_b_q;
  logic pin0_q, pin1_q;
  logic hi_act_q, lo_act_q;
  logic req_q, is_hi_q;
  ivp_src_id_t id_q;
  logic [15:0] vec_q;
  logic [NUM_SRC-1:0] chosen_q;
  logic [NUM_SRC-1:0] pend, en_vec, pr_vec, cand, hi_cand, lo_cand;
  logic hi_valid, lo_valid, pick_hi, pick_lo, req_d;
  ivp_src_id_t hi_idx, lo_idx, id_d;
  logic addr_ph, wr_en;
  logic [7:0] rd_mux;
  logic dma_any, gpio_any, spi_req;
  logic [3:0] grant_clr;

  // Bus slave: zero-wait writes, one wait cycle on reads
  assign addr_ph = hsel && hready && htrans[1];
  assign wr_en = (bus_q == BUS_WR);
  assign hreadyout = (bus_q != BUS_RD_WAIT);
  assign hresp = 1'b0;
  assign hrdata = hrdata_q;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      bus_q <= BUS_IDLE;
      idx_q <= 8'h00;
      hit_q <= 1'b0;
    end
    else if (bus_q == BUS_RD_WAIT)
    begin
      bus_q <= BUS_RD_DONE;
    end
    else if (addr_ph)
    begin
      bus_q <= hwrite ? BUS_WR : BUS_RD_WAIT;
      idx_q <= haddr[9:2];
      hit_q <= (haddr[31:10] == 22'h00_0000) && (haddr[1:0] == 2'h0);
    end
    else
    begin
      bus_q <= BUS_IDLE;
    end
  end

  always_comb
  begin
    rd_mux = 8'h00;
    if (hit_q)
    begin
      unique case (idx_q)
        `IVP_IDX_TCTRL: rd_mux = tctrl_q;
        `IVP_IDX_FLAGS_A: rd_mux = flags_a_q;
        `IVP_IDX_FLAGS_B: rd_mux = flags_b_q;
        `IVP_IDX_BASE_EN: rd_mux = base_en_q;
        `IVP_IDX_EXT_EN_A: rd_mux = ext_en_a_q;
        `IVP_IDX_EXT_EN_B: rd_mux = ext_en_b_q;
        `IVP_IDX_BASE_PRIO: rd_mux = base_pr_q;
        `IVP_IDX_EXT_PRIO_A: rd_mux = ext_pr_a_q;
        `IVP_IDX_EXT_PRIO_B: rd_mux = ext_pr_b_q;
        `IVP_IDX_STATUS: rd_mux = {hi_act_q, lo_act_q, req_q, id_q};
        default: rd_mux = 8'h00;
      endcase
    end
  end

  // Read data latched during the wait cycle so it reflects a write just before
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hrdata_q <= 32'h0000_0000;
    end
    else if (bus_q == BUS_RD_WAIT)
    begin
      hrdata_q <= {24'h00_0000, rd_mux};
    end
  end

  // Enable and priority registers
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      base_en_q <= `IVP_RST_REG;
      ext_en_a_q <= `IVP_RST_REG;
      ext_en_b_q <= `IVP_RST_REG;
      base_pr_q <= `IVP_RST_REG;
      ext_pr_a_q <= `IVP_RST_REG;
      ext_pr_b_q <= `IVP_RST_REG;
    end
    else if (wr_en && hit_q)
    begin
      if (idx_q == `IVP_IDX_BASE_EN)
        base_en_q <= hwdata[7:0] & `IVP_MASK_BASE;
      if (idx_q == `IVP_IDX_EXT_EN_A)
        ext_en_a_q <= hwdata[7:0];
      if (idx_q == `IVP_IDX_EXT_EN_B)
        ext_en_b_q <= hwdata[7:0] & `IVP_MASK_EXT_B;
      if (idx_q == `IVP_IDX_BASE_PRIO)
        base_pr_q <= hwdata[7:0] & `IVP_MASK_BASE & 8'h7F;
      if (idx_q == `IVP_IDX_EXT_PRIO_A)
        ext_pr_a_q <= hwdata[7:0];
      if (idx_q == `IVP_IDX_EXT_PRIO_B)
        ext_pr_b_q <= hwdata[7:0] & `IVP_MASK_EXT_B;
    end
  end

  // Falling edges on the external pins set their flags
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pin0_q <= 1'b1;
      pin1_q <= 1'b1;
    end
    else
    begin
      pin0_q <= ext_pin_zero_n;
      pin1_q <= ext_pin_one_n;
    end
  end

  // Timer-control flags: hardware set beats both grant clear and software write
  always_comb
  begin
    grant_clr = 4'h0;
    if (irq_ack && req_q && id_q < 5'd4)
      grant_clr[id_q[1:0]] = 1'b1;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      tctrl_q <= `IVP_RST_REG;
    end
    else
    begin
      if (wr_en && hit_q && idx_q == `IVP_IDX_TCTRL)
        tctrl_q <= hwdata[7:0];
      else
      begin
        if (grant_clr[0]) tctrl_q[`IVP_BIT_EXT0] <= 1'b0;
        if (grant_clr[1]) tctrl_q[`IVP_BIT_TMR0] <= 1'b0;
        if (grant_clr[2]) tctrl_q[`IVP_BIT_EXT1] <= 1'b0;
        if (grant_clr[3]) tctrl_q[`IVP_BIT_TMR1] <= 1'b0;
      end
      if (pin0_q && !ext_pin_zero_n) tctrl_q[`IVP_BIT_EXT0] <= 1'b1;
      if (pin1_q && !ext_pin_one_n) tctrl_q[`IVP_BIT_EXT1] <= 1'b1;
      if (timer0_ovf) tctrl_q[`IVP_BIT_TMR0] <= 1'b1;
      if (timer1_ovf) tctrl_q[`IVP_BIT_TMR1] <= 1'b1;
    end
  end

  // Extended flags: write one clears, event set wins
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      flags_a_q <= `IVP_RST_REG;
      flags_b_q <= `IVP_RST_REG;
    end
    else
    begin
      if (wr_en && hit_q && idx_q == `IVP_IDX_FLAGS_A)
        flags_a_q <= flags_a_q & ~(hwdata[7:0] & `IVP_MASK_FLAGS_A);
      if (wr_en && hit_q && idx_q == `IVP_IDX_FLAGS_B)
        flags_b_q <= flags_b_q & ~(hwdata[7:0] & `IVP_MASK_FLAGS_B);
      if (timer3_evt) flags_a_q[`IVP_BIT_TMR3] <= 1'b1;
      if (cipher_done_evt) flags_a_q[`IVP_BIT_CIPHER] <= 1'b1;
      if (timer2_evt) flags_a_q[`IVP_BIT_TMR2] <= 1'b1;
      if (sleep_timeout_evt) flags_b_q[`IVP_BIT_SLEEP] <= 1'b1;
      if (wakeup_evt) flags_b_q[`IVP_BIT_WAKE] <= 1'b1;
    end
  end

  // Level sources stay pending until cleared at their origin
  assign dma_any = |(dma_flags & dma_enables);
  assign gpio_any = |(gpio_pin_flags & ~GPIO_EXCL[GPIO_W-1:0]);
  assign spi_req = serial_done_flag && serial_local_enable;

  assign pend = {pwm_irq, gpio_any, flags_b_q[`IVP_BIT_WAKE], dma_any, spi_req,
    flags_b_q[`IVP_BIT_SLEEP], flags_a_q[`IVP_BIT_TMR3], flags_a_q[`IVP_BIT_CIPHER],
    flags_a_q[`IVP_BIT_TMR2], radio_irq, uart1_cause[0], i2c_irq, ir_tx_irq,
    uart0_cause[0], tctrl_q[`IVP_BIT_TMR1], tctrl_q[`IVP_BIT_EXT1],
    tctrl_q[`IVP_BIT_TMR0], tctrl_q[`IVP_BIT_EXT0]};
  assign en_vec = {ext_en_b_q[3:2], ext_en_a_q, base_en_q[6], ext_en_b_q[1:0],
    base_en_q[4:0]};
  assign pr_vec = {ext_pr_b_q[3:2], ext_pr_a_q, base_pr_q[6], ext_pr_b_q[1:0],
    base_pr_q[4:0]};
  assign cand = pend & en_vec & {NUM_SRC{base_en_q[`IVP_BIT_GLOBAL]}};
  assign hi_cand = cand & pr_vec;
  assign lo_cand = cand & ~pr_vec;

  ivp_lowest_pick #(.N(NUM_SRC)) u_pick_hi
  (
    .req(hi_cand),
    .valid(hi_valid),
    .idx(hi_idx)
  );

  ivp_lowest_pick #(.N(NUM_SRC)) u_pick_lo
  (
    .req(lo_cand),
    .valid(lo_valid),
    .idx(lo_idx)
  );

  // High may interrupt low; a running high routine blocks everything
  assign pick_hi = hi_valid && !hi_act_q;
  assign pick_lo = lo_valid && !hi_act_q && !lo_act_q;
  assign req_d = pick_hi || pick_lo;
  assign id_d = pick_hi ? hi_idx : lo_idx;

  // Request masked for a cycle after grant so the stale pick is not re-granted
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      req_q <= 1'b0;
      is_hi_q <= 1'b0;
      id_q <= '0;
      vec_q <= `IVP_VEC_BASE;
      chosen_q <= '0;
    end
    else
    begin
      req_q <= req_d && !irq_ack;
      is_hi_q <= pick_hi;
      id_q <= id_d;
      vec_q <= `IVP_VEC_BASE + (16'(id_d) << `IVP_VEC_SHIFT);
      chosen_q <= pick_hi ? hi_cand : lo_cand;
    end
  end

  assign irq_req = req_q;
  assign irq_vector = vec_q;

  // In-service levels track branch and return of the core
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hi_act_q <= 1'b0;
      lo_act_q <= 1'b0;
    end
    else if (irq_ack && req_q)
    begin
      if (is_hi_q)
        hi_act_q <= 1'b1;
      else
        lo_act_q <= 1'b1;
    end
    else if (irq_ret)
    begin
      if (hi_act_q)
        hi_act_q <= 1'b0;
      else
        lo_act_q <= 1'b0;
    end
  end

  a_vector_addr: assert property (@(posedge hclk) disable iff (!hresetn)
    irq_req |-> irq_vector == 16'h0003 + {8'h00, id_q, 3'b000})
    else $error("vector address mismatch");
  a_lowest_first: assert property (@(posedge hclk) disable iff (!hresetn)
    irq_req |-> (chosen_q & ~({NUM_SRC{1'b1}} << id_q)) == '0 && chosen_q[id_q])
    else $error("lower source not served first");
  a_global_gate: assert property (@(posedge hclk) disable iff (!hresetn)
    !base_en_q[7] |=> !irq_req)
    else $error("request with global enable off");
  a_high_blocks: assert property (@(posedge hclk) disable iff (!hresetn)
    hi_act_q && $past(hi_act_q) |-> !irq_req)
    else $error("preempted a high routine");
  a_low_nesting: assert property (@(posedge hclk) disable iff (!hresetn)
    $past(lo_act_q) && irq_req |-> is_hi_q)
    else $error("low preempted low routine");
  a_grant_clear: assert property (@(posedge hclk) disable iff (!hresetn)
    irq_ack && irq_req && id_q == 5'd1 && !timer0_ovf && !wr_en |=> !tctrl_q[5])
    else $error("timer0 flag not cleared on grant");
  a_event_set: assert property (@(posedge hclk) disable iff (!hresetn)
    timer3_evt ##1 1'b1 |-> flags_a_q[7])
    else $error("timer3 flag not set");
  a_one_clears: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_en && hit_q && idx_q == 8'h91 && hwdata[6] && !cipher_done_evt |=> !flags_a_q[6])
    else $error("write one did not clear");
  a_reserved_zero: assert property (@(posedge hclk) disable iff (!hresetn)
    flags_a_q[4:0] == 5'h00 && flags_b_q[7:2] == 6'h00)
    else $error("reserved flag bit set");
  a_spi_gate: assert property (@(posedge hclk) disable iff (!hresetn)
    irq_req && id_q == 5'd13 |-> $past(serial_done_flag && serial_local_enable))
    else $error("spi request without both enables");
endmodule

// *** verif/ivp_core_model.sv ***
`timescale 1ns/1ps
// Core stand-in: serves one routine at a time, of fixed length
module ivp_core_model
(
  input wire logic hclk, // System clock
  input wire logic hresetn, // Reset, low
  input wire logic irq_req, // Request from controller
  input wire logic [15:0] irq_vector, // Vector to fetch
  input wire logic [7:0] isr_len, // Routine length, at least 2
  output logic irq_ack, // Grant pulse
  output logic irq_ret, // Return pulse
  output logic [15:0] last_vec, // Last fetched vector
  output logic [7:0] grants // Grants taken
);
  logic [7:0] busy_q;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      irq_ack <= 1'b0;
      busy_q <= 8'h00;
      last_vec <= 16'h0000;
      grants <= 8'h00;
    end
    else if (irq_ack)
    begin
      // Grant counts only at the edge the controller takes it, vector of that edge
      irq_ack <= 1'b0;
      if (irq_req)
      begin
        busy_q <= isr_len;
        last_vec <= irq_vector;
        grants <= grants + 8'h01;
      end
    end
    else if (irq_req && busy_q == 8'h00)
    begin
      irq_ack <= 1'b1;
    end
    else if (busy_q != 8'h00)
    begin
      busy_q <= busy_q - 8'h01;
    end
  end

  // Return lands just as the routine ends, never beside an ack
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      irq_ret <= 1'b0;
    else
      irq_ret <= (busy_q == 8'h02);
  end
endmodule

// *** verif/int_vector_prio_ctrl_bench.sv ***
`timescale 1ns/1ps
`include "ivp_consts.svh"
module int_vector_prio_ctrl_bench;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hready;
  logic ext0_n = 1'b1;
  logic ext1_n = 1'b1;
  logic [3:0] u0c = 4'h0;
  logic ir = 1'b0;
  logic spi_done = 1'b0;
  logic spi_en = 1'b0;
  logic [23:0] dma_f = 24'h00_0000;
  logic [23:0] dma_e = 24'h00_0000;
  logic [31:0] gpio = 32'h0000_0000;
  logic [6:0] evt = 7'h00;
  logic pwm = 1'b0;
  logic irq_req, irq_ack, irq_ret;
  logic [15:0] irq_vector, last_vec;
  logic [7:0] grants, rd;
  int fail_count = 0;
  int compares = 0;

  always #20 hclk = ~hclk;
  assign hready = hreadyout;

  ivp_ctrl u_ivp_ctrl (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(), .ext_pin_zero_n(ext0_n),
    .ext_pin_one_n(ext1_n), .timer0_ovf(evt[0]), .timer1_ovf(evt[1]), .timer2_evt(evt[2]),
    .timer3_evt(evt[3]), .cipher_done_evt(evt[4]), .sleep_timeout_evt(evt[5]),
    .wakeup_evt(evt[6]), .uart0_cause(u0c), .uart1_cause(4'h0), .ir_tx_irq(ir),
    .i2c_irq(1'b0), .radio_irq(1'b0), .serial_done_flag(spi_done),
    .serial_local_enable(spi_en), .dma_flags(dma_f), .dma_enables(dma_e),
    .gpio_pin_flags(gpio), .pwm_irq(pwm),
    .irq_req(irq_req), .irq_vector(irq_vector), .irq_ack(irq_ack), .irq_ret(irq_ret));

  ivp_core_model u_ivp_core_model (.hclk(hclk), .hresetn(hresetn), .irq_req(irq_req),
    .irq_vector(irq_vector), .isr_len(8'd20), .irq_ack(irq_ack), .irq_ret(irq_ret),
    .last_vec(last_vec), .grants(grants));

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp)
    begin
      fail_count++;
      $display("BAD at %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Each phase holds until ready is seen high at a rising edge
  task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] d);
    hsel <= 1'b1;
    haddr <= {22'h0, idx, 2'b00};
    hwrite <= wr;
    htrans <= 2'b10;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'b00;
    hwdata <= {24'h0, d};
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata[7:0];
  endtask

  task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp);
    bus(1'b0, idx, 8'h00);
    chk({8'h00, rd}, {8'h00, exp});
  endtask

  task automatic pulse(input logic [6:0] v);
    evt <= v;
    @(posedge hclk);
    evt <= 7'h00;
    repeat (2) @(posedge hclk);
  endtask

  task automatic wait_g(input logic [7:0] n);
    int k;
    k = 0;
    while (grants !== n && k < 500)
    begin
      @(posedge hclk);
      k++;
    end
    chk({8'h00, grants}, {8'h00, n});
  endtask

  initial
  begin
    repeat (20000) @(posedge hclk);
    fail_count++;
    end_sim();
  end

  initial
  begin
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd_chk(`IVP_IDX_FLAGS_A, `IVP_RST_REG);
    rd_chk(`IVP_IDX_FLAGS_B, `IVP_RST_REG);
    rd_chk(`IVP_IDX_BASE_EN, `IVP_RST_REG);
    rd_chk(8'h10, 8'h00);
    pulse(7'h7C);
    rd_chk(`IVP_IDX_FLAGS_A, `IVP_MASK_FLAGS_A);
    rd_chk(`IVP_IDX_FLAGS_B, `IVP_MASK_FLAGS_B);
    bus(1'b1, `IVP_IDX_FLAGS_A, 8'h00);
    rd_chk(`IVP_IDX_FLAGS_A, 8'hE0);
    bus(1'b1, `IVP_IDX_FLAGS_A, 8'h20);
    rd_chk(`IVP_IDX_FLAGS_A, 8'hC0);
    bus(1'b1, `IVP_IDX_FLAGS_A, 8'hFF);
    bus(1'b1, `IVP_IDX_FLAGS_B, 8'h01);
    rd_chk(`IVP_IDX_FLAGS_A, 8'h00);
    rd_chk(`IVP_IDX_FLAGS_B, 8'h02);
    bus(1'b1, `IVP_IDX_FLAGS_B, 8'h02);
    // Pin falls while timer0 overflows
    ext0_n <= 1'b0;
    pulse(7'h01);
    ext0_n <= 1'b1;
    rd_chk(`IVP_IDX_TCTRL, 8'h22);
    bus(1'b1, `IVP_IDX_BASE_EN, 8'h03);
    repeat (4) @(posedge hclk);
    chk({15'h0, irq_req}, 16'h0000);
    chk({8'h00, grants}, 16'h0000);
    bus(1'b1, `IVP_IDX_BASE_EN, 8'h83);
    wait_g(8'd1);
    chk(last_vec, 16'h0003);
    wait_g(8'd2);
    chk(last_vec, 16'h000B);
    rd_chk(`IVP_IDX_TCTRL, 8'h00);
    pwm <= 1'b1;
    bus(1'b1, `IVP_IDX_EXT_EN_B, 8'h08);
    wait_g(8'd3);
    pwm <= 1'b0;
    chk(last_vec, 16'h008B);
    // Higher number wins when it alone is high priority
    bus(1'b1, `IVP_IDX_BASE_EN, 8'h03);
    pulse(7'h08);
    pwm <= 1'b1;
    bus(1'b1, `IVP_IDX_EXT_PRIO_B, 8'h08);
    bus(1'b1, `IVP_IDX_EXT_EN_A, 8'h08);
    bus(1'b1, `IVP_IDX_BASE_EN, 8'h83);
    wait_g(8'd4);
    pwm <= 1'b0;
    chk(last_vec, 16'h008B);
    wait_g(8'd5);
    chk(last_vec, 16'h005B);
    rd_chk(`IVP_IDX_FLAGS_A, 8'h80);
    bus(1'b1, `IVP_IDX_FLAGS_A, 8'h80);
    bus(1'b1, `IVP_IDX_BASE_EN, 8'h00);
    repeat (30) @(posedge hclk);
    chk({8'h00, grants}, 16'h0005);
    // Sources gated by their own qualifiers stay silent
    u0c <= 4'h2;
    spi_done <= 1'b1;
    dma_f <= 24'h00_0001;
    dma_e <= 24'h00_0002;
    gpio <= 32'h0C00_0000;
    bus(1'b1, `IVP_IDX_EXT_EN_A, 8'h60);
    bus(1'b1, `IVP_IDX_EXT_EN_B, 8'h05);
    bus(1'b1, `IVP_IDX_BASE_EN, 8'h94);
    repeat (4) @(posedge hclk);
    chk({15'h0, irq_req}, 16'h0000);
    chk({8'h00, grants}, 16'h0005);
    // Qualifiers complete; each level dropped once granted
    ext1_n <= 1'b0;
    u0c <= 4'h3;
    ir <= 1'b1;
    spi_en <= 1'b1;
    dma_e <= 24'h00_0003;
    gpio <= 32'h0C00_0100;
    wait_g(8'd6);
    chk(last_vec, 16'h0013);
    wait_g(8'd7);
    u0c <= 4'h2;
    chk(last_vec, 16'h0023);
    wait_g(8'd8);
    ir <= 1'b0;
    chk(last_vec, 16'h002B);
    wait_g(8'd9);
    spi_done <= 1'b0;
    chk(last_vec, 16'h006B);
    wait_g(8'd10);
    dma_f <= 24'h00_0000;
    chk(last_vec, 16'h0073);
    wait_g(8'd11);
    gpio <= 32'h0C00_0000;
    chk(last_vec, 16'h0083);
    ext1_n <= 1'b1;
    rd_chk(`IVP_IDX_TCTRL, 8'h00);
    repeat (40) @(posedge hclk);
    chk({8'h00, grants}, 16'h000B);
    end_sim();
  end
endmodule
